// >>> hdl/cc_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cc_delay_timer #(
  parameter int TICK_CYCLES = ofw_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  prot_if.timer pif
);
  logic [31:0] tickCnt_q;
  logic [31:0] msCnt_q;
  logic ccRecorded_q;
  logic tickEnd;
  logic expired;

  // ==================================================
  // millisecond tick and elapsed time
  assign tickEnd = (tickCnt_q == 32'(TICK_CYCLES - 1));
  assign expired = (msCnt_q >= pif.delayMs);
  assign pif.ccRecorded = ccRecorded_q;

  // divider realigned on each change so the delay is never short
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tickCnt_q <= 32'h0;
    end else if (pif.outChange || tickEnd) begin
      tickCnt_q <= 32'h0;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h1;
    end
  end

  // stops at expiry, so no overflow over the full range
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msCnt_q <= 32'h0;
    end else if (pif.outChange) begin
      msCnt_q <= 32'h0;
    end else if (tickEnd && !expired) begin
      msCnt_q <= msCnt_q + 32'h1;
    end
  end

  // record only once expired and the condition still holds
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ccRecorded_q <= 1'b0;
    end else begin
      ccRecorded_q <= pif.ccLive && expired && !pif.outChange;
    end
  end

  // ==================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_CC_RESTART: assert property (pif.outChange |=> !pif.ccRecorded)
    else $error("constant current recorded right after a change");
  AST_CC_DELAY: assert property (
    pif.outChange && pif.delayMs != 32'h0 |=> !pif.ccRecorded [*2])
    else $error("constant current recorded before the delay");
  AST_CC_ZERO: assert property (
    pif.delayMs == 32'h0 && pif.ccLive && !pif.outChange |=> pif.ccRecorded)
    else $error("zero delay did not record constant current");
endmodule : cc_delay_timer
`default_nettype wire

// >>> hdl/output_fault_control.sv
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module output_fault_control #(
  parameter logic RELAY_FITTED = 1'b1,
  parameter int TICK_CYCLES = ofw_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic ccDetect,
  input wire logic ovDetect,
  input wire logic otDetect,
  input wire logic inhibitIn,
  input wire logic fuseFault,
  input wire logic powerOnStored,
  input wire logic [7:0] statusByte,
  input wire logic levelChange,
  input wire logic [15:0] sampleIn,
  input wire logic [15:0] sampleWeight,
  output logic sourceOn,
  output logic zeroVoltage,
  output logic minCurrent,
  output logic relayClose,
  output logic discreteFaultOut,
  output logic overcurrentFlag,
  output logic powerOnChoice,
  output logic recallSlotZero,
  output logic windowRect,
  output logic [15:0] rawSampleOut,
  output logic [15:0] calcSampleOut
);
  prot_if pif ();

  logic [ofw_pkg::N_PIN-1:0] pinRaw;
  logic [ofw_pkg::N_PIN-1:0] pinMeta_q;
  logic [ofw_pkg::N_PIN-1:0] pinSync_q;
  logic setupPh;
  logic accessPh;
  logic addrOk;
  logic wrAcc;
  logic ctrlWr;
  logic cmdWr;
  logic delayWr;
  logic restore;
  logic keepRelay;
  logic [31:0] readData;
  logic [31:0] ctrlView;
  logic [31:0] statusView;
  logic [31:0] prdata_q;
  logic [ofw_pkg::SRC_W-1:0] srcField;
  ofw_pkg::faultSrc_t srcWr;
  logic [31:0] delayIn;
  logic faultEn_q;
  ofw_pkg::faultSrc_t src_q;
  logic winRect_q;
  logic ocpEn_q;
  logic ponChoice_q;
  logic [31:0] delay_q;
  logic [1:0] startCnt_q;
  logic recall_q;
  logic outEn_q;
  logic savedEn_q;
  logic relay_q;
  logic ocCause;
  logic anyCause;
  logic onNext;
  logic sourceOn_q;
  logic zeroVolt_q;
  logic minCurr_q;
  logic ocFlag_q;
  logic selBit;
  logic faultOut_q;
  logic [31:0] product;
  logic [15:0] rawOut_q;
  logic [15:0] calcOut_q;

  // ==================================================
  // pin synchronisers
  assign pinRaw = {powerOnStored, fuseFault, inhibitIn, otDetect, ovDetect, ccDetect};

  // first stage is read only by the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  // ==================================================
  // apb slave, zero wait states
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable;
  assign addrOk = (paddr == ofw_pkg::ADDR_CTRL) || (paddr == ofw_pkg::ADDR_CMD) ||
                  (paddr == ofw_pkg::ADDR_DELAY) || (paddr == ofw_pkg::ADDR_STATUS);
  assign wrAcc = accessPh && pwrite && addrOk;
  assign ctrlWr = wrAcc && (paddr == ofw_pkg::ADDR_CTRL);
  assign cmdWr = wrAcc && (paddr == ofw_pkg::ADDR_CMD);
  assign delayWr = wrAcc && (paddr == ofw_pkg::ADDR_DELAY);
  assign restore = cmdWr && pwdata[ofw_pkg::F_DEFAULTS];
  assign keepRelay = pwdata[ofw_pkg::F_KEEP_RELAY];
  assign pready = 1'b1;
  assign pslverr = accessPh && !addrOk;
  assign prdata = prdata_q;

  // read word is captured in setup, stable through the access phase
  assign readData = (paddr == ofw_pkg::ADDR_CTRL) ? ctrlView :
                    (paddr == ofw_pkg::ADDR_DELAY) ? delay_q :
                    (paddr == ofw_pkg::ADDR_STATUS) ? statusView : 32'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0;
    end else if (setupPh) begin
      prdata_q <= readData;
    end
  end

  // register views, unused bits read zero
  always_comb begin
    ctrlView = 32'h0;
    ctrlView[ofw_pkg::F_OUT_EN] = outEn_q;
    ctrlView[ofw_pkg::F_FAULT_EN] = faultEn_q;
    ctrlView[ofw_pkg::F_SRC_LO +: ofw_pkg::SRC_W] = src_q;
    ctrlView[ofw_pkg::F_WIN_RECT] = winRect_q;
    ctrlView[ofw_pkg::F_OCP_EN] = ocpEn_q;
    ctrlView[ofw_pkg::F_PON_RCL] = ponChoice_q;
    statusView = 32'h0;
    statusView[ofw_pkg::S_LATCH] = pif.latched;
    statusView[ofw_pkg::S_OC] = ocFlag_q;
    statusView[ofw_pkg::S_CC] = pif.ccRecorded;
    statusView[ofw_pkg::S_RELAY] = relay_q;
    statusView[ofw_pkg::S_OUT] = sourceOn_q;
    statusView[ofw_pkg::S_FAULT] = faultOut_q;
    statusView[ofw_pkg::S_CAUSE_LO +: ofw_pkg::N_CAUSE] = pif.cause;
  end

  // ==================================================
  // configuration registers
  assign srcField = pwdata[ofw_pkg::F_SRC_LO +: ofw_pkg::SRC_W];
  assign srcWr = (srcField > ofw_pkg::SRC_RQS) ? ofw_pkg::SRC_NONE :
                 ofw_pkg::faultSrc_t'(srcField);
  assign delayIn = (pwdata > ofw_pkg::CC_DELAY_MAX_MS) ? ofw_pkg::CC_DELAY_MAX_MS : pwdata;

  // restore command puts the same values as reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultEn_q <= ofw_pkg::FAULT_EN_RST;
      src_q <= ofw_pkg::SRC_RST;
      winRect_q <= ofw_pkg::WIN_RECT_RST;
      ocpEn_q <= ofw_pkg::OCP_EN_RST;
    end else if (restore) begin
      faultEn_q <= ofw_pkg::FAULT_EN_RST;
      src_q <= ofw_pkg::SRC_RST;
      winRect_q <= ofw_pkg::WIN_RECT_RST;
      ocpEn_q <= ofw_pkg::OCP_EN_RST;
    end else if (ctrlWr) begin
      faultEn_q <= pwdata[ofw_pkg::F_FAULT_EN];
      src_q <= srcWr;
      winRect_q <= pwdata[ofw_pkg::F_WIN_RECT];
      ocpEn_q <= pwdata[ofw_pkg::F_OCP_EN];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      delay_q <= ofw_pkg::CC_DELAY_RST_MS;
    end else if (restore) begin
      delay_q <= ofw_pkg::CC_DELAY_RST_MS;
    end else if (delayWr) begin
      delay_q <= delayIn;
    end
  end

  // ==================================================
  // power-on choice, stored copy read once synced
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      startCnt_q <= 2'h0;
      recall_q <= 1'b0;
      ponChoice_q <= 1'b0;
    end else begin
      recall_q <= 1'b0;
      if (startCnt_q != ofw_pkg::START_DONE) begin
        startCnt_q <= startCnt_q + 2'h1;
      end
      if (startCnt_q == ofw_pkg::START_CAPTURE) begin
        ponChoice_q <= pinSync_q[ofw_pkg::PIN_PON];
        recall_q <= pinSync_q[ofw_pkg::PIN_PON];
      end else if (ctrlWr) begin
        ponChoice_q <= pwdata[ofw_pkg::F_PON_RCL];
      end
    end
  end

  assign powerOnChoice = ponChoice_q;
  assign recallSlotZero = recall_q;

  // ==================================================
  // protection and delay
  assign ocCause = ocpEn_q && pif.ccRecorded;
  assign pif.cause = {pinSync_q[ofw_pkg::PIN_FUSE], pinSync_q[ofw_pkg::PIN_INH],
                      pinSync_q[ofw_pkg::PIN_OT], ocCause, pinSync_q[ofw_pkg::PIN_OV]};
  assign anyCause = |pif.cause;
  assign pif.clearReq = cmdWr && pwdata[ofw_pkg::F_PROT_CLR];
  assign pif.ccLive = pinSync_q[ofw_pkg::PIN_CC];
  assign pif.delayMs = delay_q;
  assign pif.outChange = ctrlWr || restore || levelChange || pif.clearOk;

  cc_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .pif(pif.timer)
  );

  protection_latch u_latch (
    .core_clk(core_clk),
    .rst(rst),
    .pif(pif.latch)
  );

  // ==================================================
  // output enable, relay and saved state
  // the setting survives a trip; only the effective output drops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outEn_q <= 1'b0;
      savedEn_q <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      if (anyCause && !pif.latched) begin
        savedEn_q <= outEn_q;
      end
      if (pif.clearOk) begin
        outEn_q <= savedEn_q;
      end else if (restore) begin
        outEn_q <= 1'b0;
      end else if (ctrlWr) begin
        outEn_q <= pwdata[ofw_pkg::F_OUT_EN];
      end
      if (restore) begin
        relay_q <= 1'b0;
      end else if (ctrlWr && RELAY_FITTED && !keepRelay) begin
        relay_q <= pwdata[ofw_pkg::F_OUT_EN];
      end
    end
  end

  // a live cause cuts the output in the same cycle the latch sets
  assign onNext = outEn_q && !pif.latched && !anyCause;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sourceOn_q <= 1'b0;
      zeroVolt_q <= 1'b1;
      minCurr_q <= 1'b1;
    end else begin
      sourceOn_q <= onNext;
      zeroVolt_q <= !onNext;
      minCurr_q <= !onNext;
    end
  end

  // overcurrent flag; a new trip wins over the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ocFlag_q <= 1'b0;
    end else if (ocCause) begin
      ocFlag_q <= 1'b1;
    end else if (pif.clearOk) begin
      ocFlag_q <= 1'b0;
    end
  end

  assign sourceOn = sourceOn_q;
  assign zeroVoltage = zeroVolt_q;
  assign minCurrent = minCurr_q;
  assign relayClose = relay_q;
  assign overcurrentFlag = ocFlag_q;

  // ==================================================
  // discrete fault output
  assign selBit = (src_q == ofw_pkg::SRC_QUESTIONABLE_SUMMARY_SELECT) ? statusByte[ofw_pkg::SB_QUESTIONABLE_SUMMARY_SELECT] :
                  (src_q == ofw_pkg::SRC_OPERATION_SUMMARY_SELECT) ? statusByte[ofw_pkg::SB_OPERATION_SUMMARY_SELECT] :
                  (src_q == ofw_pkg::SRC_ESB) ? statusByte[ofw_pkg::SB_ESB] :
                  (src_q == ofw_pkg::SRC_RQS) ? statusByte[ofw_pkg::SB_RQS] :
                  1'b0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultOut_q <= 1'b0;
    end else begin
      faultOut_q <= faultEn_q && selBit;
    end
  end

  assign discreteFaultOut = faultOut_q;

  // ==================================================
  // window weighting on the calculation path only
  // weight is a cos^4 coefficient, full scale just under one
  assign product = 32'(sampleIn) * 32'(sampleWeight);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rawOut_q <= 16'h0000;
      calcOut_q <= 16'h0000;
    end else begin
      rawOut_q <= sampleIn;
      calcOut_q <= winRect_q ? sampleIn : product[31:16];
    end
  end

  assign windowRect = winRect_q;
  assign rawSampleOut = rawOut_q;
  assign calcSampleOut = calcOut_q;

  // ==================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence trip_s;
    ocpEn_q && pif.ccRecorded;
  endsequence

  sequence shut_s;
    !sourceOn && overcurrentFlag && pif.latched;
  endsequence

  AST_OFF_ZERO: assert property (!sourceOn |-> zeroVoltage && minCurrent)
    else $error("disabled output not at zero volts and min current");
  AST_RELAY_FOLLOW: assert property (
    ctrlWr && !keepRelay && !restore |=> relayClose == $past(pwdata[ofw_pkg::F_OUT_EN]))
    else $error("relay did not follow output enable");
  AST_RELAY_KEEP: assert property (ctrlWr && keepRelay |=> $stable(relayClose))
    else $error("relay moved under keep-relay qualifier");
  AST_RESTORE: assert property (
    restore |=> !faultEn_q && src_q == ofw_pkg::SRC_NONE && !windowRect)
    else $error("restore left fault output or window set");
  AST_DFI_QUESTIONABLE_SUMMARY_SELECT: assert property (
    faultEn_q && src_q == ofw_pkg::SRC_QUESTIONABLE_SUMMARY_SELECT |=> discreteFaultOut == $past(statusByte[3]))
    else $error("fault output not following status bit 3");
  AST_DFI_OPERATION_SUMMARY_SELECT: assert property (
    faultEn_q && src_q == ofw_pkg::SRC_OPERATION_SUMMARY_SELECT |=> discreteFaultOut == $past(statusByte[7]))
    else $error("fault output not following status bit 7");
  AST_DFI_ESB: assert property (
    faultEn_q && src_q == ofw_pkg::SRC_ESB |=> discreteFaultOut == $past(statusByte[5]))
    else $error("fault output not following status bit 5");
  AST_DFI_RQS: assert property (
    faultEn_q && src_q == ofw_pkg::SRC_RQS |=> discreteFaultOut == $past(statusByte[6]))
    else $error("fault output not following status bit 6");
  AST_DFI_OFF: assert property (
    !faultEn_q || src_q == ofw_pkg::SRC_NONE |=> !discreteFaultOut)
    else $error("fault output high while disabled or no source");
  AST_CLEAR_RESTORE: assert property (
    pif.clearOk |=> outEn_q == $past(savedEn_q))
    else $error("clear did not restore pre-fault enable");
  AST_OC_TRIP: assert property (trip_s |=> shut_s)
    else $error("overcurrent trip did not shut down and flag");
  AST_OV_NODELAY: assert property (
    pinSync_q[ofw_pkg::PIN_OV] |=> !sourceOn ##1 pif.latched)
    else $error("overvoltage shutdown was delayed");
  AST_RAW_SAMPLE: assert property (!$past(rst) |-> rawSampleOut == $past(sampleIn))
    else $error("raw sample altered");
  AST_RECT_CALC: assert property (windowRect |=> calcSampleOut == $past(sampleIn))
    else $error("rectangular window weighted the sample");
endmodule : output_fault_control
`default_nettype wire

// >>> hdl/protection_latch.sv
`timescale 1ns/1ps
`default_nettype none
module protection_latch (
  input wire logic core_clk,
  input wire logic rst,
  prot_if.latch pif
);
  logic latched_q;
  logic anyCause;

  // ==================================================
  // fault latch
  assign anyCause = |pif.cause;
  assign pif.clearOk = pif.clearReq && !anyCause;
  assign pif.latched = latched_q;

  // a fault in the clear cycle wins, so a live cause is never dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latched_q <= 1'b0;
    end else if (anyCause) begin
      latched_q <= 1'b1;
    end else if (pif.clearOk) begin
      latched_q <= 1'b0;
    end
  end

  // ==================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_LATCH_SET: assert property (anyCause |=> pif.latched)
    else $error("fault did not set the latch");
  AST_CLEAR_BLOCK: assert property (pif.clearReq && anyCause |=> pif.latched)
    else $error("clear released latch with a live cause");
  AST_CLEAR_OK: assert property (pif.latched && pif.clearOk |=> !pif.latched)
    else $error("clear with no cause kept the latch");
endmodule : protection_latch
`default_nettype wire

// >>> include/ofw_pkg.sv
`default_nettype none
package ofw_pkg;
  // ==================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam real CC_DELAY_RST_S = 0.08;
  localparam real CC_DELAY_MAX_S = 2147483.647;
  localparam logic [31:0] CC_DELAY_RST_MS = 32'(int'(CC_DELAY_RST_S * 1000.0));
  localparam logic [31:0] CC_DELAY_MAX_MS = 32'(int'(CC_DELAY_MAX_S * 1000.0));
  localparam logic [1:0] START_CAPTURE = 2'h2;
  localparam logic [1:0] START_DONE = 2'h3;
  // ==================================================
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // ==================================================
  // field positions
  localparam int F_OUT_EN = 0;
  localparam int F_KEEP_RELAY = 1;
  localparam int F_FAULT_EN = 2;
  localparam int F_SRC_LO = 4;
  localparam int SRC_W = 3;
  localparam int F_WIN_RECT = 8;
  localparam int F_OCP_EN = 9;
  localparam int F_PON_RCL = 10;
  localparam int F_PROT_CLR = 0;
  localparam int F_DEFAULTS = 1;
  localparam int S_LATCH = 0;
  localparam int S_OC = 1;
  localparam int S_CC = 2;
  localparam int S_RELAY = 3;
  localparam int S_OUT = 4;
  localparam int S_FAULT = 5;
  localparam int S_CAUSE_LO = 8;
  localparam int SB_QUESTIONABLE_SUMMARY_SELECT = 3;
  localparam int SB_ESB = 5;
  localparam int SB_RQS = 6;
  localparam int SB_OPERATION_SUMMARY_SELECT = 7;
  localparam int N_CAUSE = 5;
  localparam int PIN_CC = 0;
  localparam int PIN_OV = 1;
  localparam int PIN_OT = 2;
  localparam int PIN_INH = 3;
  localparam int PIN_FUSE = 4;
  localparam int PIN_PON = 5;
  localparam int N_PIN = 6;
  // ==================================================
  // modes and reset values
  typedef enum logic [SRC_W-1:0] {SRC_NONE, SRC_QUESTIONABLE_SUMMARY_SELECT, SRC_OPERATION_SUMMARY_SELECT, SRC_ESB, SRC_RQS} faultSrc_t;
  localparam logic FAULT_EN_RST = 1'b0;
  localparam faultSrc_t SRC_RST = SRC_NONE;
  localparam logic WIN_RECT_RST = 1'b0;
  localparam logic OCP_EN_RST = 1'b0;
endpackage : ofw_pkg
`default_nettype wire

// >>> include/prot_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// protection and delay links inside the block
interface prot_if;
  logic outChange;
  logic ccLive;
  logic [31:0] delayMs;
  logic ccRecorded;
  logic [ofw_pkg::N_CAUSE-1:0] cause;
  logic clearReq;
  logic latched;
  logic clearOk;
  modport timer (input outChange, input ccLive, input delayMs, output ccRecorded);
  modport latch (input cause, input clearReq, output latched, output clearOk);
endinterface : prot_if
`default_nettype wire

// >>> sim/apb_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// host controller model: plain APB master
module apb_host (
  input wire logic core_clk,
  output var logic [7:0] paddr,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // bus idle from time zero
  initial begin
    paddr = 8'h00;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    pwdata = 32'h0;
  end
  // request held until pready is seen at a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
endmodule : apb_host
`default_nettype wire

// >>> sim/test_output_fault_and_window_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module test_output_fault_and_window_control;
  logic core_clk = 1'h0, rst = 1'h1, psel, penable, pwrite, pready, pslverr, ccDetect = 1'h0;
  logic [7:0] paddr, statusByte = 8'h00;
  logic [31:0] pwdata, prdata, q;
  logic e, sourceOn, zeroVoltage, minCurrent, relayClose, discreteFaultOut, overcurrentFlag;
  logic [3:0] flt = 4'h0;
  logic [15:0] sampleIn = 16'h8000, sampleWeight = 16'h8000, rawSampleOut, calcSampleOut;
  logic windowRect, powerOnStored = 1'h0, powerOnChoice, recallSlotZero, levelChange = 1'h0;
  int errors = 0, num_checks = 0;
  int bits[4] = '{3, 7, 5, 6};
  always #2 core_clk = ~core_clk;
  apb_host host (.core_clk, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
    .pslverr);
  output_fault_control #(.TICK_CYCLES(4)) dut (.core_clk, .rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pready, .prdata, .pslverr, .ccDetect, .ovDetect(flt[0]),
    .otDetect(flt[1]), .inhibitIn(flt[2]), .fuseFault(flt[3]), .powerOnStored,
    .statusByte, .levelChange, .sampleIn, .sampleWeight, .sourceOn, .zeroVoltage,
    .minCurrent, .relayClose, .discreteFaultOut, .overcurrentFlag, .powerOnChoice,
    .recallSlotZero, .windowRect, .rawSampleOut, .calcSampleOut);
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask : w
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(a, 1'h1, d, q, e);
  endtask : wr
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // ==================================================
  // hang guard, well past the expected few hundred cycles
  initial begin
    w(20000);
    errors++;
    results();
  end
  // ==================================================
  // tests
  initial begin
    w(4);
    rst <= 1'h0;
    w(1);
    // defaults after reset: disabled output, no source, raised-cosine
    `CHK("zeroV", 1'h1, zeroVoltage)
    `CHK("minI", 1'h1, minCurrent)
    host.xfer(ofw_pkg::ADDR_CTRL, 1'h0, 32'h0, q, e);
    `CHK("ctrl", 32'h0, q)
    host.xfer(ofw_pkg::ADDR_DELAY, 1'h0, 32'h0, q, e);
    `CHK("delay", ofw_pkg::CC_DELAY_RST_MS, q)
    host.xfer(8'h10, 1'h0, 32'h0, q, e);
    `CHK("unmapped", 1'h1, e)
    $display("test reset done");
    // each source picks its own status bit, nothing else
    for (int s = 0; s < 5; s++) begin
      wr(ofw_pkg::ADDR_CTRL, 32'h4 | 32'(s) << 4);
      statusByte <= (s == 0) ? 8'hFF : 8'h01 << bits[s - 1];
      w(3);
      `CHK("dfoOn", s != 0, discreteFaultOut)
      statusByte <= (s == 0) ? 8'hFF : ~(8'h01 << bits[s - 1]);
      w(3);
      `CHK("dfoOff", 1'h0, discreteFaultOut)
    end
    wr(ofw_pkg::ADDR_CTRL, 32'h10);
    w(3);
    `CHK("dfoDis", 1'h0, discreteFaultOut)
    $display("test fault output done");
    // enable with relay, then disable keeping the relay
    wr(ofw_pkg::ADDR_CTRL, 32'h1);
    w(4);
    `CHK("on", 1'h1, sourceOn)
    `CHK("relayOn", 1'h1, relayClose)
    wr(ofw_pkg::ADDR_CTRL, 32'h2);
    w(4);
    `CHK("zeroV2", 1'h1, zeroVoltage)
    `CHK("relayKept", 1'h1, relayClose)
    $display("test relay done");
    // every pin latching cause (ov, ot, inhibit, fuse); the controller clears only once causes are gone
    wr(ofw_pkg::ADDR_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      flt <= 4'h1 << i;
      w(5);
      `CHK("trip", 1'h0, sourceOn)
      wr(ofw_pkg::ADDR_CMD, 32'h1);
      w(4);
      `CHK("heldLive", 1'h0, sourceOn)
      flt <= 4'h0;
      w(4);
      `CHK("held", 1'h0, sourceOn)
      wr(ofw_pkg::ADDR_CMD, 32'h1);
      w(4);
      `CHK("restored", 1'h1, sourceOn)
    end
    $display("test latch done");
    // 5 ms delay, 4 cycles a tick; a level change restarts the wait
    wr(ofw_pkg::ADDR_DELAY, 32'h5);
    wr(ofw_pkg::ADDR_CTRL, 32'h201);
    ccDetect <= 1'h1;
    w(10);
    `CHK("ocEarly", 1'h1, sourceOn)
    levelChange <= 1'h1;
    w(1);
    levelChange <= 1'h0;
    w(19);
    `CHK("ocRestart", 1'h1, sourceOn)
    `CHK("flagEarly", 1'h0, overcurrentFlag)
    w(5);
    `CHK("ocTrip", 1'h0, sourceOn)
    `CHK("ocFlag", 1'h1, overcurrentFlag)
    ccDetect <= 1'h0;
    w(4);
    wr(ofw_pkg::ADDR_CMD, 32'h1);
    w(4);
    `CHK("ocClr", 1'h0, overcurrentFlag)
    `CHK("ocBack", 1'h1, sourceOn)
    $display("test overcurrent done");
    // steady samples under raised-cosine, then rectangular
    w(2);
    `CHK("raw", 16'h8000, rawSampleOut)
    `CHK("cos", 16'h4000, calcSampleOut)
    wr(ofw_pkg::ADDR_CTRL, 32'h100);
    w(3);
    `CHK("rectSel", 1'h1, windowRect)
    `CHK("rect", 16'h8000, calcSampleOut)
    `CHK("raw2", 16'h8000, rawSampleOut)
    `CHK("relayOff", 1'h0, relayClose)
    // zero delay records constant current at once
    wr(ofw_pkg::ADDR_DELAY, 32'h0);
    ccDetect <= 1'h1;
    w(4);
    host.xfer(ofw_pkg::ADDR_STATUS, 1'h0, 32'h0, q, e);
    `CHK("ccZero", 32'h1 << ofw_pkg::S_CC, q)
    ccDetect <= 1'h0;
    wr(ofw_pkg::ADDR_CMD, 32'h2);
    host.xfer(ofw_pkg::ADDR_CTRL, 1'h0, 32'h0, q, e);
    `CHK("restore", 32'h0, q)
    host.xfer(ofw_pkg::ADDR_DELAY, 1'h0, 32'h0, q, e);
    `CHK("delayRst", ofw_pkg::CC_DELAY_RST_MS, q)
    $display("test window done");
    // stored choice recalls slot 0 once after a fresh reset
    powerOnStored <= 1'h1;
    rst <= 1'h1;
    w(4);
    rst <= 1'h0;
    w(4);
    `CHK("recall", 1'h1, recallSlotZero)
    `CHK("ponChoice", 1'h1, powerOnChoice)
    w(1);
    `CHK("recallOnce", 1'h0, recallSlotZero)
    $display("test power-on done");
    results();
  end
endmodule : test_output_fault_and_window_control
`default_nettype wire
